/* src/pdcc_pkg.sv */
// Package: register map, field layout and types of the PLL and divider clock configuration
package pdcc_pkg;
    // ------------------------------------------------------------
    // Register map (index; byte address is index times four)
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 10;
    localparam logic [7:0] IDX_SEC_SRC = 8'h33;
    localparam logic [7:0] IDX_NM_SRC = 8'h34;
    localparam logic [7:0] IDX_PREDIV = 8'h35;
    localparam logic [7:0] IDX_MULT_HI = 8'h36;
    localparam logic [7:0] IDX_FRAC_LO = 8'h37;
    localparam logic [7:0] IDX_INT_LO = 8'h38;
    localparam logic [7:0] IDX_ND_PD = 8'h39;
    localparam logic [7:0] IDX_AUTO = 8'h40;
    localparam logic [7:0] IDX_STATUS = 8'h41;
    // ------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] RST_SEC_SRC = 8'h00;
    localparam logic [7:0] RST_NM_SRC = 8'h10;
    localparam logic [7:0] RST_PREDIV = 8'h01;
    localparam logic [7:0] RST_MULT_HI = 8'h00;
    localparam logic [7:0] RST_FRAC_LO = 8'h00;
    localparam logic [7:0] RST_INT_LO = 8'h08;
    localparam logic [7:0] RST_ND_PD = 8'h20;
    localparam logic [7:0] SEC_SRC_WMASK = 8'h70;
    localparam int unsigned SEC_SRC_LSB = 4;
    localparam int unsigned DIG_SRC_LSB = 6;
    localparam int unsigned ANA_SRC_LSB = 4;
    localparam int unsigned INT_HI_BIT = 7;
    localparam int unsigned HALVE_BIT = 6;
    localparam int unsigned NSTAGE_LSB = 5;
    localparam int unsigned PDM_LSB = 2;
    // ------------------------------------------------------------
    // Arithmetic limits
    // ------------------------------------------------------------
    localparam logic [8:0] PREDIV_ZERO_VAL = 9'h100;
    localparam logic [3:0] NSTAGE_ZERO_VAL = 4'h8;
    localparam logic [13:0] FRAC_MAX = 14'h270f;
    localparam logic [13:0] FRAC_SCALE = 14'h2710;
    localparam logic [2:0] PDM_MAX_CODE = 3'h4;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {SEC_PLL, SEC_PRI_BCLK, SEC_EXT_CLK, SEC_OSC, SEC_DSP} pdcc_sec_src_t;
    typedef enum logic [1:0] {DIG_PRI_BCLK, DIG_SEC_BCLK, DIG_EXT_CLK, DIG_OSC} pdcc_dig_src_t;
    typedef enum logic [1:0] {ANA_PLL, ANA_DIG_SRC, ANA_PRI_LOWJIT} pdcc_ana_src_t;
    typedef struct packed {
        pdcc_sec_src_t sec_src;
        pdcc_dig_src_t dig_src;
        pdcc_ana_src_t ana_src;
    } pdcc_clk_sel_t;
    typedef struct packed {
        logic [8:0] prediv;
        logic [8:0] jmul;
        logic [13:0] dmul;
        logic halve;
        logic [3:0] n_stage;
        logic [4:0] pdm_ratio;
        logic [22:0] mult_scaled;
    } pdcc_pll_cfg_t;
    typedef struct packed {
        logic [7:0] pdiv;
        logic [8:0] jmul;
        logic [13:0] dmul;
        logic [2:0] n_stage;
        logic [2:0] pdm;
    } pdcc_auto_t;
endpackage

/* src/pdcc_clock_config.sv */
// Top module: clock source selects, PLL and divider settings behind an Avalon-MM slave
// Functional notes
// - Secondary bit clock divider source: 0 PLL,1 primary,3 external,4 oscillator,5 DSP.
// - Digital N/M source: 0 primary,1 secondary,2 external,3 oscillator clock.
// - Analog N/M source resets 1; 0/1 PLL, 2 digital source, 3 low-jitter primary.
// - Pre-divider divides by its code; code 0 divides by 256.
// - Integer multiplier is nine bits, high bit joined to low byte; 1 to 511.
// - Fractional multiplier is fourteen bits, 0 to 9999; larger codes not allowed.
// - Bit 6 adds a divide-by-two on the PLL divider clock.
// - N divider resets to 1, divides by code; code 0 divides by 8.
// - Pulse-density divider code 0..4 gives ratio 1,2,4,8,16; 5..7 reserved.
// - Automatic detection overrides pre-divider, multipliers, N and pulse-density fields.
`timescale 1ns/100ps
module pdcc_clock_config (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [pdcc_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire pdcc_pkg::pdcc_auto_t auto_cfg_i,
    output pdcc_pkg::pdcc_clk_sel_t clk_sel_o,
    output pdcc_pkg::pdcc_pll_cfg_t pll_cfg_o
);
    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    logic wait_q;
    logic [31:0] rdata_q;
    logic [7:0] rdata_d;
    logic req;
    logic wr_en;
    logic [7:0] idx;

    assign req = avs_read_i || avs_write_i;
    assign idx = avs_address_i[pdcc_pkg::ADDR_W-1:2];
    // A write lands only at the edge where the master sees waitrequest low
    assign wr_en = avs_write_i && !wait_q && avs_byteenable_i[0];
    assign avs_waitrequest_o = wait_q;
    assign avs_readdata_o = rdata_q;

    // One wait cycle per access keeps read data registered
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= !(req && wait_q);
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (avs_read_i && wait_q) begin
            rdata_q <= {24'h00_0000, rdata_d};
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    logic [7:0] sec_q;
    logic [7:0] nm_q;
    logic [7:0] pdiv_q;
    logic [7:0] hi_q;
    logic [7:0] dlo_q;
    logic [7:0] jlo_q;
    logic [7:0] ndpd_q;
    logic auto_q;
    logic [7:0] wd;

    assign wd = avs_writedata_i[7:0];

    // Read-only reserved bits of the secondary source register are masked off so they always read zero
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sec_q <= pdcc_pkg::RST_SEC_SRC;
        end else if (wr_en && idx == pdcc_pkg::IDX_SEC_SRC) begin
            sec_q <= wd & pdcc_pkg::SEC_SRC_WMASK;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            nm_q <= pdcc_pkg::RST_NM_SRC;
            pdiv_q <= pdcc_pkg::RST_PREDIV;
            hi_q <= pdcc_pkg::RST_MULT_HI;
        end else if (wr_en) begin
            if (idx == pdcc_pkg::IDX_NM_SRC) begin
                nm_q <= wd;
            end
            if (idx == pdcc_pkg::IDX_PREDIV) begin
                pdiv_q <= wd;
            end
            if (idx == pdcc_pkg::IDX_MULT_HI) begin
                hi_q <= wd;
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dlo_q <= pdcc_pkg::RST_FRAC_LO;
            jlo_q <= pdcc_pkg::RST_INT_LO;
            ndpd_q <= pdcc_pkg::RST_ND_PD;
        end else if (wr_en) begin
            if (idx == pdcc_pkg::IDX_FRAC_LO) begin
                dlo_q <= wd;
            end
            if (idx == pdcc_pkg::IDX_INT_LO) begin
                jlo_q <= wd;
            end
            if (idx == pdcc_pkg::IDX_ND_PD) begin
                ndpd_q <= wd;
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            auto_q <= 1'b0;
        end else if (wr_en && idx == pdcc_pkg::IDX_AUTO) begin
            auto_q <= wd[0];
        end
    end

    // ------------------------------------------------------------
    // Field selection and decoding
    // ------------------------------------------------------------
    logic [2:0] sec_code;
    logic [1:0] dig_code;
    logic [1:0] ana_code;
    logic [7:0] pdiv_c;
    logic [8:0] j_c;
    logic [13:0] d_c;
    logic [13:0] d_lim;
    logic [2:0] nd_c;
    logic [2:0] pdm_c;
    logic [7:0] status;
    pdcc_pkg::pdcc_clk_sel_t sel_d;
    pdcc_pkg::pdcc_clk_sel_t sel_q;
    pdcc_pkg::pdcc_pll_cfg_t cfg_d;
    pdcc_pkg::pdcc_pll_cfg_t cfg_q;

    assign sec_code = sec_q[pdcc_pkg::SEC_SRC_LSB +: 3];
    assign dig_code = nm_q[pdcc_pkg::DIG_SRC_LSB +: 2];
    assign ana_code = nm_q[pdcc_pkg::ANA_SRC_LSB +: 2];

    // While detection runs, the detector's codes replace the programmed ones
    always_comb begin
        if (auto_q) begin
            pdiv_c = auto_cfg_i.pdiv;
            j_c = auto_cfg_i.jmul;
            d_c = auto_cfg_i.dmul;
            nd_c = auto_cfg_i.n_stage;
            pdm_c = auto_cfg_i.pdm;
        end else begin
            pdiv_c = pdiv_q;
            j_c = {hi_q[pdcc_pkg::INT_HI_BIT], jlo_q};
            d_c = {hi_q[5:0], dlo_q};
            nd_c = ndpd_q[pdcc_pkg::NSTAGE_LSB +: 3];
            pdm_c = ndpd_q[pdcc_pkg::PDM_LSB +: 3];
        end
    end

    // Out-of-range fractions are clamped so the frequency word stays bounded
    assign d_lim = (d_c > pdcc_pkg::FRAC_MAX) ? pdcc_pkg::FRAC_MAX : d_c;

    always_comb begin
        sel_d = sel_q;
        case (sec_code)
            3'h0: sel_d.sec_src = pdcc_pkg::SEC_PLL;
            3'h1: sel_d.sec_src = pdcc_pkg::SEC_PRI_BCLK;
            3'h3: sel_d.sec_src = pdcc_pkg::SEC_EXT_CLK;
            3'h4: sel_d.sec_src = pdcc_pkg::SEC_OSC;
            3'h5: sel_d.sec_src = pdcc_pkg::SEC_DSP;
            // Reserved codes keep the last legal source, avoiding a glitchy switch
            default: sel_d.sec_src = sel_q.sec_src;
        endcase
        case (dig_code)
            2'h0: sel_d.dig_src = pdcc_pkg::DIG_PRI_BCLK;
            2'h1: sel_d.dig_src = pdcc_pkg::DIG_SEC_BCLK;
            2'h2: sel_d.dig_src = pdcc_pkg::DIG_EXT_CLK;
            default: sel_d.dig_src = pdcc_pkg::DIG_OSC;
        endcase
        case (ana_code)
            2'h0, 2'h1: sel_d.ana_src = pdcc_pkg::ANA_PLL;
            2'h2: sel_d.ana_src = pdcc_pkg::ANA_DIG_SRC;
            default: sel_d.ana_src = pdcc_pkg::ANA_PRI_LOWJIT;
        endcase
    end

    always_comb begin
        cfg_d = cfg_q;
        cfg_d.prediv = (pdiv_c == 8'h00) ? pdcc_pkg::PREDIV_ZERO_VAL : {1'b0, pdiv_c};
        cfg_d.jmul = j_c;
        cfg_d.dmul = d_lim;
        cfg_d.halve = hi_q[pdcc_pkg::HALVE_BIT];
        cfg_d.n_stage = (nd_c == 3'h0) ? pdcc_pkg::NSTAGE_ZERO_VAL : {1'b0, nd_c};
        if (pdm_c <= pdcc_pkg::PDM_MAX_CODE) begin
            cfg_d.pdm_ratio = 5'(5'h01 << pdm_c);
        end
        // Output frequency = input / prediv * mult_scaled / 10000
        cfg_d.mult_scaled = 23'(j_c * pdcc_pkg::FRAC_SCALE) + 23'(d_lim);
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sel_q <= '{pdcc_pkg::SEC_PLL, pdcc_pkg::DIG_PRI_BCLK, pdcc_pkg::ANA_PLL};
        end else begin
            sel_q <= sel_d;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cfg_q <= '{9'h001, 9'h008, 14'h0000, 1'b0, 4'h1, 5'h01, 23'h01_3880};
        end else begin
            cfg_q <= cfg_d;
        end
    end

    assign clk_sel_o = sel_q;
    assign pll_cfg_o = cfg_q;

    // ------------------------------------------------------------
    // Status and read multiplexer
    // ------------------------------------------------------------
    // Level flags: illegal codes now in effect, plus the detection mode
    assign status = {3'h0,
        (d_c > pdcc_pkg::FRAC_MAX),
        (j_c == 9'h000),
        (pdm_c > pdcc_pkg::PDM_MAX_CODE),
        (sec_code == 3'h2 || sec_code > 3'h5),
        auto_q};

    always_comb begin
        case (idx)
            pdcc_pkg::IDX_SEC_SRC: rdata_d = sec_q;
            pdcc_pkg::IDX_NM_SRC: rdata_d = nm_q;
            pdcc_pkg::IDX_PREDIV: rdata_d = pdiv_q;
            pdcc_pkg::IDX_MULT_HI: rdata_d = hi_q;
            pdcc_pkg::IDX_FRAC_LO: rdata_d = dlo_q;
            pdcc_pkg::IDX_INT_LO: rdata_d = jlo_q;
            pdcc_pkg::IDX_ND_PD: rdata_d = ndpd_q;
            pdcc_pkg::IDX_AUTO: rdata_d = {7'h00, auto_q};
            pdcc_pkg::IDX_STATUS: rdata_d = status;
            default: rdata_d = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    sequence s_held_req;
        req && wait_q ##1 !wait_q;
    endsequence
    property p_bus_answer;
        (req && wait_q) |-> s_held_req ##1 wait_q;
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("Access not answered in one wait cycle");

    property p_sec_src;
        (sec_code == 3'h3) |=> (clk_sel_o.sec_src == pdcc_pkg::SEC_EXT_CLK);
    endproperty
    a_sec_src: assert property (p_sec_src)
        else $error("Secondary source code 3 not external clock");

    property p_sec_rsvd;
        (sec_code == 3'h2) |=> $stable(clk_sel_o.sec_src);
    endproperty
    a_sec_rsvd: assert property (p_sec_rsvd)
        else $error("Reserved secondary code changed source");

    property p_dig_src;
        (dig_code == 2'h1) |=> (clk_sel_o.dig_src == pdcc_pkg::DIG_SEC_BCLK);
    endproperty
    a_dig_src: assert property (p_dig_src)
        else $error("Digital source code 1 not secondary clock");

    property p_ana_src;
        (ana_code <= 2'h1) |=> (clk_sel_o.ana_src == pdcc_pkg::ANA_PLL);
    endproperty
    a_ana_src: assert property (p_ana_src)
        else $error("Analog source codes 0 and 1 must pick PLL");

    property p_prediv;
        (!auto_q && pdiv_q == 8'h00) |=> (pll_cfg_o.prediv == 9'h100);
    endproperty
    a_prediv: assert property (p_prediv)
        else $error("Pre-divider code 0 not 256");

    property p_jmul;
        !auto_q |=> (pll_cfg_o.jmul == $past({hi_q[7], jlo_q}));
    endproperty
    a_jmul: assert property (p_jmul)
        else $error("Integer multiplier not joined from registers");

    property p_dmul;
        (!auto_q && {hi_q[5:0], dlo_q} <= 14'h270f) |=> (pll_cfg_o.dmul == $past({hi_q[5:0], dlo_q}));
    endproperty
    a_dmul: assert property (p_dmul)
        else $error("Fractional multiplier not joined from registers");

    property p_halve;
        hi_q[6] |=> pll_cfg_o.halve;
    endproperty
    a_halve: assert property (p_halve)
        else $error("Divide-by-two bit not applied");

    property p_nstage;
        (!auto_q && ndpd_q[7:5] == 3'h0) |=> (pll_cfg_o.n_stage == 4'h8);
    endproperty
    a_nstage: assert property (p_nstage)
        else $error("N divider code 0 not 8");

    property p_pdm;
        (!auto_q && ndpd_q[4:2] == 3'h4) |=> (pll_cfg_o.pdm_ratio == 5'h10);
    endproperty
    a_pdm: assert property (p_pdm)
        else $error("Pulse-density code 4 not ratio 16");

    property p_auto;
        (auto_q && auto_cfg_i.pdiv != 8'h00) |=> (pll_cfg_o.prediv == {1'b0, $past(auto_cfg_i.pdiv)});
    endproperty
    a_auto: assert property (p_auto)
        else $error("Detected pre-divider not used in auto mode");

    property p_freq;
        (pll_cfg_o.dmul <= 14'h270f) |->
            (pll_cfg_o.mult_scaled == 23'(pll_cfg_o.jmul * 14'h2710) + 23'(pll_cfg_o.dmul));
    endproperty
    a_freq: assert property (p_freq)
        else $error("Frequency word not integer times 10000 plus fraction");
endmodule

/* testbench/tb_top.sv */
// Self-checking testbench for the PLL and divider clock configuration block
`timescale 1ns/100ps
module tb_top;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [pdcc_pkg::ADDR_W-1:0] avs_address_i = '0;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = '0;
    logic [3:0] avs_byteenable_i = 4'h1;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    pdcc_pkg::pdcc_auto_t auto_cfg_i = '0;
    pdcc_pkg::pdcc_clk_sel_t clk_sel_o;
    pdcc_pkg::pdcc_pll_cfg_t pll_cfg_o;
    int n_mismatch = 0;
    int n_tests = 0;
    logic [31:0] rd;
    logic [7:0] idx_tab [8];
    logic [7:0] rst_tab [8];
    int prev;
    always #10 clk_i = ~clk_i;
    pdcc_clock_config dut (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .auto_cfg_i(auto_cfg_i),
        .clk_sel_o(clk_sel_o), .pll_cfg_o(pll_cfg_o)
    );
    // ------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Holds the request until waitrequest is sampled low; no fixed latency assumed
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge clk_i);
        avs_address_i <= {idx, 2'b00};
        avs_writedata_i <= {24'h0, wd};
        avs_read_i <= ~wr;
        avs_write_i <= wr;
        do begin
            @(posedge clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 50);
        if (n >= 50) begin
            chk("waitrequest", 32'h0, 32'(avs_waitrequest_o));
        end
        rd = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask
    // Outputs follow the register one edge after acceptance; the task waits two edges
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
        repeat (2) @(posedge clk_i);
    endtask
    task automatic rdchk(input string what, input logic [7:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        chk(what, {24'h0, exp}, rd);
    endtask
    task automatic pchk(input int pd, input int j, input int dm, input int h, input int nd, input int pr);
        chk("prediv", 32'(pd), 32'(pll_cfg_o.prediv));
        chk("jmul", 32'(j), 32'(pll_cfg_o.jmul));
        chk("dmul", 32'(dm), 32'(pll_cfg_o.dmul));
        chk("halve", 32'(h), 32'(pll_cfg_o.halve));
        chk("n_stage", 32'(nd), 32'(pll_cfg_o.n_stage));
        chk("pdm_ratio", 32'(pr), 32'(pll_cfg_o.pdm_ratio));
        chk("mult_scaled", 32'(j * 10000 + dm), 32'(pll_cfg_o.mult_scaled));
    endtask
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        test_done();
    end
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        idx_tab = '{pdcc_pkg::IDX_SEC_SRC, pdcc_pkg::IDX_NM_SRC, pdcc_pkg::IDX_PREDIV, pdcc_pkg::IDX_MULT_HI,
                    pdcc_pkg::IDX_FRAC_LO, pdcc_pkg::IDX_INT_LO, pdcc_pkg::IDX_ND_PD, pdcc_pkg::IDX_AUTO};
        rst_tab = '{8'h00, 8'h10, 8'h01, 8'h00, 8'h00, 8'h08, 8'h20, 8'h00};
        repeat (10) @(posedge clk_i);
        arst_n_i <= 1'b1;
        for (int i = 0; i < 8; i++) rdchk("reset value", idx_tab[i], rst_tab[i]);
        pchk(1, 8, 0, 0, 1, 1);
        chk("ana_src", 32'(pdcc_pkg::ANA_PLL), 32'(clk_sel_o.ana_src));
        $display("test reset done");
        // Reserved codes leave the previous source in place
        prev = 0;
        for (int c = 0; c < 8; c++) begin
            wr(pdcc_pkg::IDX_SEC_SRC, 8'(c << 4));
            if (c == 1) prev = 1;
            if (c >= 3 && c <= 5) prev = c - 1;
            chk("sec_src", 32'(prev), 32'(clk_sel_o.sec_src));
        end
        wr(pdcc_pkg::IDX_SEC_SRC, 8'h70);
        rdchk("sec_src readback", pdcc_pkg::IDX_SEC_SRC, 8'h70);
        $display("test secondary source done");
        for (int d = 0; d < 4; d++) begin
            for (int a = 0; a < 4; a++) begin
                wr(pdcc_pkg::IDX_NM_SRC, 8'((d << 6) | (a << 4)));
                chk("dig_src", 32'(d), 32'(clk_sel_o.dig_src));
                chk("ana_src", (a < 2) ? 32'(pdcc_pkg::ANA_PLL) : (a == 2) ? 32'(pdcc_pkg::ANA_DIG_SRC)
                    : 32'(pdcc_pkg::ANA_PRI_LOWJIT), 32'(clk_sel_o.ana_src));
            end
        end
        rdchk("nm readback", pdcc_pkg::IDX_NM_SRC, 8'hf0);
        $display("test nm sources done");
        foreach (rst_tab[i]) begin
            prev = (i == 0) ? 0 : (i == 1) ? 1 : (i == 2) ? 2 : 255;
            if (i < 4) begin
                wr(pdcc_pkg::IDX_PREDIV, 8'(prev));
                chk("prediv", (prev == 0) ? 32'd256 : 32'(prev), 32'(pll_cfg_o.prediv));
            end
        end
        $display("test prediv done");
        wr(pdcc_pkg::IDX_MULT_HI, 8'he7);
        wr(pdcc_pkg::IDX_FRAC_LO, 8'h0f);
        wr(pdcc_pkg::IDX_INT_LO, 8'hff);
        pchk(255, 511, 9999, 1, 1, 1);
        wr(pdcc_pkg::IDX_MULT_HI, 8'h27);
        pchk(255, 255, 9999, 0, 1, 1);
        rdchk("status legal", pdcc_pkg::IDX_STATUS, 8'h02);
        wr(pdcc_pkg::IDX_MULT_HI, 8'h00);
        wr(pdcc_pkg::IDX_FRAC_LO, 8'h00);
        wr(pdcc_pkg::IDX_INT_LO, 8'h01);
        pchk(255, 1, 0, 0, 1, 1);
        $display("test multipliers done");
        for (int n = 0; n < 8; n++) begin
            wr(pdcc_pkg::IDX_ND_PD, 8'(n << 5));
            chk("n_stage", (n == 0) ? 32'd8 : 32'(n), 32'(pll_cfg_o.n_stage));
        end
        prev = 1;
        for (int p = 0; p < 8; p++) begin
            wr(pdcc_pkg::IDX_ND_PD, 8'(8'h20 | (p << 2)));
            if (p < 5) prev = 1 << p;
            chk("pdm_ratio", 32'(prev), 32'(pll_cfg_o.pdm_ratio));
        end
        rdchk("status reserved codes", pdcc_pkg::IDX_STATUS, 8'h06);
        $display("test n and pdm done");
        wr(pdcc_pkg::IDX_MULT_HI, 8'h40);
        wr(pdcc_pkg::IDX_ND_PD, 8'h40);
        @(posedge clk_i);
        auto_cfg_i <= '{pdiv: 8'h00, jmul: 9'h1f4, dmul: 14'h04d2, n_stage: 3'h0, pdm: 3'h3};
        wr(pdcc_pkg::IDX_AUTO, 8'h01);
        pchk(256, 500, 1234, 1, 8, 8);
        @(posedge clk_i);
        // Detector codes are not bound by the software range, so the clamp is tried here
        auto_cfg_i <= '{pdiv: 8'h05, jmul: 9'h1f4, dmul: 14'h3fff, n_stage: 3'h0, pdm: 3'h3};
        repeat (3) @(posedge clk_i);
        chk("auto prediv", 32'd5, 32'(pll_cfg_o.prediv));
        chk("auto dmul clamp", 32'd9999, 32'(pll_cfg_o.dmul));
        rdchk("status clamp", pdcc_pkg::IDX_STATUS, 8'h13);
        wr(pdcc_pkg::IDX_AUTO, 8'h00);
        pchk(255, 1, 0, 1, 2, 1);
        $display("test auto detection done");
        // Unmapped place and a write with no byte enabled
        wr(8'h3a, 8'h55);
        rdchk("unmapped", 8'h3a, 8'h00);
        avs_byteenable_i <= 4'h0;
        wr(pdcc_pkg::IDX_PREDIV, 8'h09);
        avs_byteenable_i <= 4'h1;
        rdchk("byteenable", pdcc_pkg::IDX_PREDIV, 8'hff);
        $display("test refusals done");
        test_done();
    end
endmodule
